// [verilog/gpa_port.sv]
/*
 * Eight-pin general purpose port with direction, latch and pin read, and pin sharing.
 * Assumes an APB master on pclk; pad inputs are synchronous to pclk after the two-stage stage here.
 */
// The register addresses and the APB slave port were left to the implementer.
// Function
// [R1] Eight pins, each with direction bit, latch bit and input path.
// [R2] Direction 1 floats the driver; direction 0 drives the latch.
// [R3] Port read returns pin levels; port write updates the latch.
// [R4] Latch register is separately readable and writable.
// [R5] Pins 6 and 7 read zero in port, direction, latch when oscillator-owned.
// [R6] Pin 6 is I/O only in I/O oscillator modes; crystal uses feedback.
// [R7] Clock-out modes drive quarter oscillator clock on pin 6 regardless of direction.
// [R8] Pin 7 digital I/O is off when the oscillator uses it.
// [R9] Converter control bits select analog use of pins 0-3 and 5.
// [R10] After reset pins 0-3 and 5 are analog, read zero; pin 4 digital.
// [R11] Analog selection disables digital input, not the output driver.
// [R12] Software keeps direction set to input for analog pins.
// [R13] Software turns comparators off before digital input use of pins 0-3.
// [R14] Enabled comparator outputs override the latch on pins 4 and 5.
// [R15] Reference output on pin 2 disables its digital input and output.
// [R16] Pin 4 input feeds the timer zero external clock.
// [R17] Pin 5 input feeds the serial port slave select.
// [R18] An enabled peripheral owns its pin over general purpose use; comparator outputs drive pins 4 and 5 only while their direction bit is 0.
// [R19] Pins are synchronised before read; writes land at the write edge.
`timescale 1ns/10ps
`default_nettype none
module gpa_port
   import gpa_pkg::*;
#(
   parameter int unsigned WIDTH = GPA_WIDTH
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [WIDTH-1:0]  pad_in,
   output logic      [WIDTH-1:0]  pad_out,
   output logic      [WIDTH-1:0]  pad_oe,
   input  wire logic              comparator_one_output,
   input  wire logic              comparator_two_output,
   output logic                   timer_zero_ext_clock,
   output logic                   slave_select_in,
   output logic      [3:0]        converter_ctrl_one
);
   logic [WIDTH-1:0] direction_reg;
   logic [WIDTH-1:0] output_latch_reg;
   logic [3:0]       conv_reg;
   logic [2:0]       comparator_ctrl;
   logic [3:0]       osc_reg;
   logic [WIDTH-1:0] sync_a_reg;
   logic [WIDTH-1:0] pin_level_reg;
   logic [1:0]       div_reg;
   logic             cycle_clock_reg;
   logic [31:0]      prdata_reg;
   logic             pslverr_reg;
   logic [WIDTH-1:0] pad_out_reg;
   logic [WIDTH-1:0] pad_oe_reg;
   logic             tmr_reg;
   logic             ss_reg;

   wire logic        acc_w = psel && penable && pwrite;
   wire logic        acc_r = psel && penable && !pwrite;
   wire logic        wr_pin = acc_w && (paddr == GPA_OFF_PIN_LEVEL);
   wire logic        wr_lat = acc_w && (paddr == GPA_OFF_LATCH);
   wire logic        wr_dir = acc_w && (paddr == GPA_OFF_DIRECTION);
   wire logic        wr_conv = acc_w && (paddr == GPA_OFF_CONV_CTRL);
   wire logic        wr_comp = acc_w && (paddr == GPA_OFF_COMP_CTRL);
   wire logic        wr_osc = acc_w && (paddr == GPA_OFF_OSC_CFG);
   wire logic        mapped = (paddr == GPA_OFF_PIN_LEVEL) || (paddr == GPA_OFF_LATCH)
                            || (paddr == GPA_OFF_DIRECTION) || (paddr == GPA_OFF_CONV_CTRL)
                            || (paddr == GPA_OFF_COMP_CTRL) || (paddr == GPA_OFF_OSC_CFG);

   // Oscillator ownership of pins 6 and 7.
   wire logic        p6_io = (osc_reg == GPA_RES_CAP_IO) || (osc_reg == GPA_INT_OSC_IO)
                           || (osc_reg == GPA_EXT_CLOCK_IO);                     // [R6]
   wire logic        p6_clk = (osc_reg == GPA_RES_CAP_OUT) || (osc_reg == GPA_INT_OSC_CLKOUT)
                            || (osc_reg == GPA_EXT_CLOCK_OUT);                   // [R7]
   wire logic        p7_io = (osc_reg == GPA_INT_OSC_IO) || (osc_reg == GPA_INT_OSC_CLKOUT); // [R8]
   wire logic [WIDTH-1:0] osc_keep = {p7_io, p6_io, {(WIDTH-2){1'b1}}};          // [R5]

   // Analog selection from the converter control field; all-ones code is fully digital.
   wire logic [WIDTH-1:0] analog_sel = (conv_reg == GPA_CONV_ALL_DIGITAL) ? '0
                                     : GPA_ANALOG_MASK[WIDTH-1:0];              // [R9]
   wire logic [WIDTH-1:0] ref_sel = {{(WIDTH-3){1'b0}},
                                     comparator_ctrl[GPA_COMP_REF_OUT_BIT], 2'b00};
   // Digital input disabled by analog, reference output or oscillator use.
   wire logic [WIDTH-1:0] in_enable = ~analog_sel & ~ref_sel & osc_keep;        // [R11] [R15]
   wire logic [WIDTH-1:0] port_view = pin_level_reg & in_enable;                // [R3] [R10]

   function automatic logic [WIDTH-1:0] sel_bits(input logic [WIDTH-1:0] v,
                                                 input logic [WIDTH-1:0] m);
      sel_bits = v & m;
   endfunction

   logic [WIDTH-1:0] drv_out;
   logic [WIDTH-1:0] drv_oe;
   always_comb begin
      drv_out = output_latch_reg;                                                // [R2]
      drv_oe  = ~direction_reg & osc_keep & ~ref_sel;                            // [R2] [R15] [R18]
      if (comparator_ctrl[GPA_COMP_OUT_ONE_BIT] && !direction_reg[4]) begin
         drv_out[4] = comparator_one_output;                                     // [R14]
      end
      if (comparator_ctrl[GPA_COMP_OUT_TWO_BIT] && !direction_reg[5]) begin
         drv_out[5] = comparator_two_output;                                     // [R14]
      end
      if (p6_clk) begin
         drv_out[6] = cycle_clock_reg;                                           // [R7]
         drv_oe[6]  = 1'b1;
      end
   end

   wire logic [31:0] rd_mux =
        (paddr == GPA_OFF_PIN_LEVEL) ? {24'h000000, port_view} :
        (paddr == GPA_OFF_LATCH)     ? {24'h000000, sel_bits(output_latch_reg, osc_keep)} : // [R4] [R5]
        (paddr == GPA_OFF_DIRECTION) ? {24'h000000, sel_bits(direction_reg, osc_keep)} :
        (paddr == GPA_OFF_CONV_CTRL) ? {28'h0000000, conv_reg} :
        (paddr == GPA_OFF_COMP_CTRL) ? {29'h00000000, comparator_ctrl} :
        (paddr == GPA_OFF_OSC_CFG)   ? {28'h0000000, osc_reg} : 32'h00000000;

   // Registers; a pin-level write lands in the latch, never on the pad.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_latch_reg <= GPA_RST_LATCH;
         direction_reg    <= GPA_RST_DIRECTION;
         conv_reg         <= GPA_RST_CONV_CTRL;                                  // [R10]
         comparator_ctrl  <= GPA_RST_COMP_CTRL;
         osc_reg          <= GPA_RST_OSC_CFG;
      end else begin
         if (wr_pin || wr_lat) begin
            output_latch_reg <= pwdata[WIDTH-1:0];                               // [R3] [R19]
         end
         if (wr_dir) begin
            direction_reg <= pwdata[WIDTH-1:0];                                  // [R1] [R19]
         end
         if (wr_conv) begin
            conv_reg <= pwdata[3:0];
         end
         if (wr_comp) begin
            comparator_ctrl <= pwdata[2:0];
         end
         if (wr_osc) begin
            osc_reg <= pwdata[3:0];
         end
      end
   end

   // Two flops keep metastability off the read path at the cost of two cycles latency.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_a_reg    <= '0;
         pin_level_reg <= '0;
      end else begin
         sync_a_reg    <= pad_in;
         pin_level_reg <= sync_a_reg;                                            // [R19]
      end
   end

   // Quarter-rate cycle clock; pclk stands in for the oscillator here.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg         <= 2'h0;
         cycle_clock_reg <= 1'b0;
      end else begin
         div_reg <= div_reg + 2'h1;
         if (div_reg[0]) begin
            cycle_clock_reg <= ~cycle_clock_reg;                                 // [R7]
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg  <= 32'h00000000;
         pslverr_reg <= 1'b0;
         pad_out_reg <= '0;
         pad_oe_reg  <= '0;
         tmr_reg     <= 1'b0;
         ss_reg      <= 1'b1;
      end else begin
         prdata_reg  <= (psel && !penable && !pwrite) ? rd_mux : prdata_reg;
         pslverr_reg <= psel && !penable && !mapped;
         pad_out_reg <= drv_out;
         pad_oe_reg  <= drv_oe;
         tmr_reg     <= pin_level_reg[4] & direction_reg[4];                     // [R16]
         ss_reg      <= ~direction_reg[5] | pin_level_reg[5];                    // [R17]
      end
   end

   assign prdata  = prdata_reg;
   assign pready  = 1'b1;
   assign pslverr = pslverr_reg;
   assign pad_out = pad_out_reg;
   assign pad_oe  = pad_oe_reg;
   assign timer_zero_ext_clock = tmr_reg;
   assign slave_select_in      = ss_reg;
   assign converter_ctrl_one   = conv_reg;

   // Assertions.
   property p_dir_in;
      @(posedge pclk) disable iff (!presetn)
      (direction_reg[0] && !ref_sel[0]) |=> !pad_oe[0];
   endproperty
   a_dir_in: assert property (p_dir_in) else $error("input pin driven"); // [R2]
   property p_dir_out;
      @(posedge pclk) disable iff (!presetn)
      !direction_reg[1] |=> (pad_oe[1] && pad_out[1] == $past(output_latch_reg[1]));
   endproperty
   a_dir_out: assert property (p_dir_out) else $error("output pin not driving latch"); // [R2]
   property p_lat_write;
      @(posedge pclk) disable iff (!presetn)
      wr_pin |=> output_latch_reg == $past(pwdata[WIDTH-1:0]);
   endproperty
   a_lat_write: assert property (p_lat_write) else $error("port write missed latch"); // [R3]
   property p_osc_zero;
      @(posedge pclk) disable iff (!presetn)
      (!p7_io && acc_r) |-> rd_mux[7] == 1'b0;
   endproperty
   a_osc_zero: assert property (p_osc_zero) else $error("oscillator pin bit read nonzero"); // [R5]
   property p_clkout;
      @(posedge pclk) disable iff (!presetn)
      p6_clk |=> pad_oe[6];
   endproperty
   a_clkout: assert property (p_clkout) else $error("clock out not driven"); // [R7]
   property p_analog_zero;
      @(posedge pclk) disable iff (!presetn)
      (conv_reg != GPA_CONV_ALL_DIGITAL) |-> port_view[0] == 1'b0;
   endproperty
   a_analog_zero: assert property (p_analog_zero) else $error("analog pin reads nonzero"); // [R11]
   property p_cmp_one;
      @(posedge pclk) disable iff (!presetn)
      (comparator_ctrl[0] && !direction_reg[4]) |=> pad_out[4] == $past(comparator_one_output);
   endproperty
   a_cmp_one: assert property (p_cmp_one) else $error("comparator one not on pin"); // [R14]
   property p_ref_off;
      @(posedge pclk) disable iff (!presetn)
      comparator_ctrl[2] |=> !pad_oe[2];
   endproperty
   a_ref_off: assert property (p_ref_off) else $error("reference pin driven"); // [R15]
   property p_sync;
      @(posedge pclk) disable iff (!presetn)
      1'b1 |-> ##2 pin_level_reg == $past(pad_in, 2);
   endproperty
   a_sync: assert property (p_sync) else $error("sync latency wrong"); // [R19]
   property p_pin6_off;
      @(posedge pclk) disable iff (!presetn)
      (!p6_io && !p6_clk) |=> !pad_oe[6];
   endproperty
   a_pin6_off: assert property (p_pin6_off) else $error("oscillator pin six driven"); // [R6]
   property p_pin7_off;
      @(posedge pclk) disable iff (!presetn)
      !p7_io |=> !pad_oe[7];
   endproperty
   a_pin7_off: assert property (p_pin7_off) else $error("oscillator pin seven driven"); // [R8]
   property p_cmp_two;
      @(posedge pclk) disable iff (!presetn)
      (comparator_ctrl[GPA_COMP_OUT_TWO_BIT] && !direction_reg[5])
         |=> pad_out[5] == $past(comparator_two_output);
   endproperty
   a_cmp_two: assert property (p_cmp_two) else $error("comparator two not on pin"); // [R14]
   property p_ref_in;
      @(posedge pclk) disable iff (!presetn)
      comparator_ctrl[GPA_COMP_REF_OUT_BIT] |-> port_view[2] == 1'b0;
   endproperty
   a_ref_in: assert property (p_ref_in) else $error("reference pin reads nonzero"); // [R15]
   property p_analog_drive;
      @(posedge pclk) disable iff (!presetn)
      !direction_reg[0] |=> pad_oe[0] && pad_out[0] == $past(output_latch_reg[0]);
   endproperty
   a_analog_drive: assert property (p_analog_drive) else $error("analog pin not driven"); // [R11]
   property p_timer_feed;
      @(posedge pclk) disable iff (!presetn)
      direction_reg[4] |=> timer_zero_ext_clock == $past(pin_level_reg[4]);
   endproperty
   a_timer_feed: assert property (p_timer_feed) else $error("timer clock not fed"); // [R16]
   property p_select_feed;
      @(posedge pclk) disable iff (!presetn)
      direction_reg[5] |=> slave_select_in == $past(pin_level_reg[5]);
   endproperty
   a_select_feed: assert property (p_select_feed) else $error("slave select not fed"); // [R17]
   property p_dir_write;
      @(posedge pclk) disable iff (!presetn)
      wr_dir |=> direction_reg == $past(pwdata[WIDTH-1:0]);
   endproperty
   a_dir_write: assert property (p_dir_write) else $error("direction write missed"); // [R19]
   property p_latch_read;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == GPA_OFF_LATCH)
         |=> prdata[WIDTH-1:0] == ($past(output_latch_reg) & $past(osc_keep));
   endproperty
   a_latch_read: assert property (p_latch_read) else $error("latch read wrong"); // [R4]
   property p_cycle_half;
      @(posedge pclk) disable iff (!presetn)
      $changed(cycle_clock_reg) |=> $stable(cycle_clock_reg);
   endproperty
   a_cycle_half: assert property (p_cycle_half) else $error("cycle clock too fast"); // [R7]
   property p_bad_addr;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !mapped) |=> pslverr;
   endproperty
   a_bad_addr: assert property (p_bad_addr) else $error("unmapped access not flagged");
   c_write_latch: cover property (@(posedge pclk) wr_lat);
   c_read_pins: cover property (@(posedge pclk) acc_r && paddr == GPA_OFF_PIN_LEVEL);
   c_clkout: cover property (@(posedge pclk) p6_clk);
   c_cmp: cover property (@(posedge pclk) comparator_ctrl[1] && !direction_reg[5]);
endmodule // gpa_port
`default_nettype wire

// [verilog/gpa_pkg.sv]
/*
 * Package for the eight-pin general purpose port with pin sharing.
 * Holds register offsets, field positions, reset values and mode codes; assumes APB, 32-bit data.
 */
package gpa_pkg;
   localparam int unsigned GPA_WIDTH = 8;
   localparam logic [11:0] GPA_OFF_PIN_LEVEL = 12'h000;
   localparam logic [11:0] GPA_OFF_LATCH     = 12'h004;
   localparam logic [11:0] GPA_OFF_DIRECTION = 12'h008;
   localparam logic [11:0] GPA_OFF_CONV_CTRL = 12'h00c;
   localparam logic [11:0] GPA_OFF_COMP_CTRL = 12'h010;
   localparam logic [11:0] GPA_OFF_OSC_CFG   = 12'h014;
   localparam logic [7:0] GPA_RST_DIRECTION = 8'hff;
   localparam logic [7:0] GPA_RST_LATCH     = 8'h00;
   localparam logic [3:0] GPA_RST_CONV_CTRL = 4'h0;
   localparam logic [3:0] GPA_RST_OSC_CFG   = 4'h0;
   localparam logic [2:0] GPA_RST_COMP_CTRL = 3'h0;
   localparam logic [3:0] GPA_CONV_ALL_DIGITAL = 4'hf;
   localparam int unsigned GPA_COMP_OUT_ONE_BIT = 0;
   localparam int unsigned GPA_COMP_OUT_TWO_BIT = 1;
   localparam int unsigned GPA_COMP_REF_OUT_BIT = 2;
   localparam int unsigned GPA_CYCLE_DIV = 4;
   localparam logic [7:0] GPA_ANALOG_MASK = 8'h2f;
   typedef enum logic [3:0] {
      GPA_LOW_POWER_CRYSTAL   = 4'h0,
      GPA_STANDARD_CRYSTAL    = 4'h1,
      GPA_HIGH_SPEED_CRYSTAL  = 4'h2,
      GPA_RES_CAP_OUT         = 4'h3,
      GPA_RES_CAP_IO          = 4'h4,
      GPA_INT_OSC_CLKOUT      = 4'h5,
      GPA_INT_OSC_IO          = 4'h6,
      GPA_EXT_CLOCK_OUT       = 4'h7,
      GPA_EXT_CLOCK_IO        = 4'h8
   } gpa_osc_mode_type;
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } gpa_pad_type;
endpackage

// [dv/gpa_pin_model.sv]
/*
 * Pin-side model of the eight pads and the outside world behind them.
 * Assumes pad_oe high means the port drives the pin, and one clock pclk.
 */
`timescale 1ns/10ps
`default_nettype none
module gpa_pin_model (
   input  wire logic       pclk,
   input  wire logic [7:0] pad_out,
   input  wire logic [7:0] pad_oe,
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   output logic      [7:0] pad_in
);
   logic [7:0] float_reg = 8'h55;
   // A pin nobody drives has no pull, so it shows a pattern that changes every cycle.
   always @(posedge pclk) begin
      float_reg <= ~float_reg;
   end
   // Where the port drives, the wire follows the port; outside drivers only fill the rest.
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                 | (~pad_oe & ~ext_en & float_reg);
endmodule // gpa_pin_model
`default_nettype wire

// [dv/tb_gpio_port_a_with_pin_mux.sv]
/*
 * Self-checking bench for the general purpose port with pin sharing.
 * Assumes the port answers APB with pready and that the pin model closes the pads.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_gpio_port_a_with_pin_mux;
   import gpa_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  pad_in;
   logic [7:0]  pad_out;
   logic [7:0]  pad_oe;
   logic        cmp_one = 1'b0;
   logic        cmp_two = 1'b0;
   logic        timer_clk;
   logic        slave_sel;
   logic [3:0]  conv_ctrl;
   logic [7:0]  ext_en = 8'hff;
   logic [7:0]  ext_val = 8'hff;
   logic [31:0] rd;
   logic        er;
   logic [3:0]  pin6_seq;
   int          errors = 0;
   int          checks_done = 0;
   gpa_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
      .comparator_one_output(cmp_one), .comparator_two_output(cmp_two),
      .timer_zero_ext_clock(timer_clk), .slave_select_in(slave_sel),
      .converter_ctrl_one(conv_ctrl));
   gpa_pin_model u_pins (.pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe), .ext_en(ext_en),
      .ext_val(ext_val), .pad_in(pad_in));
   initial begin
      forever #25 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // The master holds the whole request until pready is seen high at an edge, for at most 16 edges.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         errors++;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Pads follow a write one edge later and pin reads lag two edges, so four are ample.
   task automatic settle;
      repeat (4) @(posedge pclk);
      @(negedge pclk);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge pclk);
      errors++;
      close_out();
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      chk({24'h0, pad_oe}, 32'h0);
      apb(1'b0, GPA_OFF_DIRECTION, 32'h0);
      chk(rd, 32'h3f);
      apb(1'b0, GPA_OFF_PIN_LEVEL, 32'h0);
      chk(rd, 32'h10);
      apb(1'b0, GPA_OFF_CONV_CTRL, 32'h0);
      chk(rd, 32'h0);
      chk({28'h0, conv_ctrl}, 32'h0);
      chk({31'h0, pready}, 32'h1);
      apb(1'b0, 12'h020, 32'h0);
      chk({rd[30:0], er}, 32'h1);
      $display("test reset done");
      apb(1'b1, GPA_OFF_OSC_CFG, 32'(GPA_INT_OSC_IO));
      apb(1'b1, GPA_OFF_COMP_CTRL, 32'h0);
      apb(1'b1, GPA_OFF_CONV_CTRL, {28'h0, GPA_CONV_ALL_DIGITAL});
      apb(1'b1, GPA_OFF_PIN_LEVEL, 32'ha5);
      apb(1'b0, GPA_OFF_LATCH, 32'h0);
      chk(rd, 32'ha5);
      chk({28'h0, conv_ctrl}, {28'h0, GPA_CONV_ALL_DIGITAL});
      apb(1'b1, GPA_OFF_DIRECTION, 32'h0);
      settle();
      chk({16'h0, pad_oe, pad_out}, 32'hffa5);
      @(posedge pclk);
      ext_val <= 8'h5a;
      apb(1'b1, GPA_OFF_DIRECTION, 32'hf0);
      settle();
      apb(1'b0, GPA_OFF_PIN_LEVEL, 32'h0);
      chk(rd, 32'h55);
      chk({30'h0, timer_clk, slave_sel}, 32'h2);
      apb(1'b1, GPA_OFF_DIRECTION, 32'h0f);
      apb(1'b1, GPA_OFF_CONV_CTRL, 32'h0);
      settle();
      chk({30'h0, timer_clk, slave_sel}, 32'h1);
      chk({24'h0, pad_oe}, 32'hf0);
      apb(1'b0, GPA_OFF_PIN_LEVEL, 32'h0);
      chk(rd, 32'h80);
      $display("test latch and pins done");
      apb(1'b1, GPA_OFF_CONV_CTRL, {28'h0, GPA_CONV_ALL_DIGITAL});
      apb(1'b1, GPA_OFF_DIRECTION, 32'h0);
      cmp_one <= 1'b1;
      ext_val <= 8'hff;
      apb(1'b1, GPA_OFF_COMP_CTRL, 32'h3);
      settle();
      chk({30'h0, pad_out[5:4]}, 32'h1);
      apb(1'b1, GPA_OFF_COMP_CTRL, 32'h4);
      settle();
      chk({31'h0, pad_oe[2]}, 32'h0);
      apb(1'b0, GPA_OFF_PIN_LEVEL, 32'h0);
      chk(rd, 32'ha1);
      apb(1'b1, GPA_OFF_COMP_CTRL, 32'h0);
      $display("test comparators done");
      for (int m = 0; m < 9; m++) begin
         apb(1'b1, GPA_OFF_OSC_CFG, 32'(m));
         apb(1'b1, GPA_OFF_DIRECTION, 32'hff);
         settle();
         chk({24'h0, pad_oe}, (m == 3 || m == 5 || m == 7) ? 32'h40 : 32'h0);
         for (int k = 0; k < 4; k++) begin
            @(negedge pclk);
            pin6_seq[k] = pad_out[6];
         end
         chk({31'h0, pin6_seq[0] ^ pin6_seq[2]}, {31'h0, m == 3 || m == 5 || m == 7});
         chk({31'h0, pin6_seq[1] ^ pin6_seq[3]}, {31'h0, m == 3 || m == 5 || m == 7});
         apb(1'b0, GPA_OFF_DIRECTION, 32'h0);
         chk(rd, {24'h0, m == 5 || m == 6, m == 4 || m == 6 || m == 8, 6'h3f});
         apb(1'b1, GPA_OFF_DIRECTION, 32'h0);
         settle();
         chk({31'h0, pad_oe[7]}, {31'h0, m == 5 || m == 6});
      end
      $display("test oscillator modes done");
      close_out();
   end
endmodule // tb_gpio_port_a_with_pin_mux
`default_nettype wire
